// ===== shared/uart_stat_pkg.sv
// ---------------------------------------------------------------------------
// Shared constants and carriers of the UART status and soft-reset block.
// ---------------------------------------------------------------------------
package uart_stat_pkg;

   // ------------------------------------------------------------------------
   // Register byte addresses.
   // ------------------------------------------------------------------------
   localparam logic [31:0] ADDR_STATUS     = 32'h5000117C;
   localparam logic [31:0] ADDR_TX_LEVEL   = 32'h50001180;
   localparam logic [31:0] ADDR_RX_LEVEL   = 32'h50001184;
   localparam logic [31:0] ADDR_SOFT_RST   = 32'h50001188;
   localparam logic [31:0] ADDR_IRQ_STATUS = 32'h500011C0;
   localparam logic [31:0] ADDR_IRQ_MASK   = 32'h500011C4;

   // ------------------------------------------------------------------------
   // Queue geometry.
   // ------------------------------------------------------------------------
   localparam int          LEVEL_W    = 5;
   localparam logic [4:0]  FIFO_DEPTH = 5'h10;
   localparam logic [4:0]  LEVEL_ZERO = 5'h00;

   // ------------------------------------------------------------------------
   // Field positions.
   // ------------------------------------------------------------------------
   localparam int ST_BUSY      = 0;
   localparam int ST_TX_NFULL  = 1;
   localparam int ST_TX_EMPTY  = 2;
   localparam int ST_RX_NEMPTY = 3;
   localparam int ST_RX_FULL   = 4;
   localparam int SR_CTRL_RST  = 0;
   localparam int SR_RX_FLUSH  = 1;
   localparam int SR_TX_FLUSH  = 2;
   localparam int IRQ_TX_EMPTY = 0;
   localparam int IRQ_RX_AVAIL = 1;
   localparam int IRQ_RX_FULL  = 2;
   localparam int IRQ_W        = 3;

   // ------------------------------------------------------------------------
   // Reset values.
   // ------------------------------------------------------------------------
   localparam logic [2:0]  IRQ_MASK_RESET = 3'h0;
   localparam logic [31:0] RDATA_RESET    = 32'h00000000;
   localparam logic [1:0]  RSYNC_RESET    = 2'h0;

   // ------------------------------------------------------------------------
   // Carriers and state records.
   // ------------------------------------------------------------------------
   typedef struct packed {
      logic push;
      logic pop;
   } fifo_evt_t;

   typedef struct packed {
      logic [LEVEL_W-1:0] level;
   } cnt_state_t;

   typedef struct packed {
      logic [1:0] stages;
   } rsync_state_t;

   typedef struct packed {
      logic              waitreq;
      logic [31:0]       rdata;
      logic [IRQ_W-1:0]  cap_irq;
      logic              act_s1;
      logic              act_s2;
      logic              act_s3;
      logic              act_flt;
      logic              tx_flush;
      logic              rx_flush;
      logic              soft_rst_req;
      logic [IRQ_W-1:0]  irq_status;
      logic [IRQ_W-1:0]  irq_mask;
      logic              irq;
      logic              prev_tx_empty;
      logic              prev_rx_nempty;
      logic              prev_rx_full;
   } top_state_t;

endpackage : uart_stat_pkg

// ===== src/occupancy_counter.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------------------
// Entry counter that mirrors one queue's fill level.
// ---------------------------------------------------------------------------
module occupancy_counter (
   input  wire logic                              i_core_clk,
   input  wire logic                              i_nrst,
   input  wire uart_stat_pkg::fifo_evt_t          i_evt,
   input  wire logic                              i_clear,
   output logic [uart_stat_pkg::LEVEL_W-1:0]      o_level
);

   uart_stat_pkg::cnt_state_t st_r;
   uart_stat_pkg::cnt_state_t st_nxt;

   // A clear beats any push or pop in the same cycle, so the queue is seen as empty at once.
   always_comb begin
      st_nxt = st_r;
      if (i_clear) begin
         st_nxt.level = uart_stat_pkg::LEVEL_ZERO;
      end else if (i_evt.push && !i_evt.pop && st_r.level != uart_stat_pkg::FIFO_DEPTH) begin
         st_nxt.level = st_r.level + 5'h01;
      end else if (i_evt.pop && !i_evt.push && st_r.level != uart_stat_pkg::LEVEL_ZERO) begin
         st_nxt.level = st_r.level - 5'h01;
      end
   end

   // State register.
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         st_r.level <= uart_stat_pkg::LEVEL_ZERO;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_level = st_r.level;

   AST_LEVEL_BOUND: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      st_r.level <= uart_stat_pkg::FIFO_DEPTH) else $error("Queue level above depth.");

endmodule : occupancy_counter

// ===== src/reset_release_sync.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------------------
// Reset that asserts at once and releases on the second clock edge.
// ---------------------------------------------------------------------------
module reset_release_sync (
   input  wire logic i_core_clk,
   input  wire logic i_nrst,
   input  wire logic i_rst_req,
   output logic      o_rst_n
);

   uart_stat_pkg::rsync_state_t st_r;
   uart_stat_pkg::rsync_state_t st_nxt;
   logic                        arst_n;

   // The request comes from a flop, so the combined reset cannot glitch.
   assign arst_n = i_nrst & ~i_rst_req;

   // Shift a one in after release; two stages keep the release clean of metastability.
   always_comb begin
      st_nxt        = st_r;
      st_nxt.stages = {st_r.stages[0], 1'b1};
   end

   // State register with asynchronous assertion.
   always_ff @(posedge i_core_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_r.stages <= uart_stat_pkg::RSYNC_RESET;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_rst_n = st_r.stages[1];

endmodule : reset_release_sync

// ===== src/uart_status_ctrl.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------------------
// Status, queue level and soft-reset registers of the UART.
// ---------------------------------------------------------------------------
module uart_status_ctrl (
   input  wire logic                     i_core_clk,
   input  wire logic                     i_nrst,
   // Avalon-MM slave.
   input  wire logic [31:0]              i_avs_address,
   input  wire logic                     i_avs_read,
   input  wire logic                     i_avs_write,
   input  wire logic [31:0]              i_avs_writedata,
   input  wire logic [3:0]               i_avs_byteenable,
   output logic [31:0]                   o_avs_readdata,
   output logic                          o_avs_waitrequest,
   // Queue traffic from the UART core.
   input  wire uart_stat_pkg::fifo_evt_t i_tx_evt,
   input  wire uart_stat_pkg::fifo_evt_t i_rx_evt,
   input  wire logic                     i_fcr_tx_flush,
   input  wire logic                     i_fcr_rx_flush,
   input  wire logic                     i_serial_active,
   // Controls to the UART core.
   output logic                          o_tx_flush,
   output logic                          o_rx_flush,
   output logic                          o_ctrl_rst_n,
   output logic                          o_serial_rst_n,
   output logic                          o_irq
);

   // ------------------------------------------------------------------------
   // Declarations.
   // ------------------------------------------------------------------------
   uart_stat_pkg::top_state_t                 st_r;
   uart_stat_pkg::top_state_t                 st_nxt;
   logic [uart_stat_pkg::LEVEL_W-1:0]         tx_level;
   logic [uart_stat_pkg::LEVEL_W-1:0]         rx_level;
   logic                                      ctrl_rst_n;
   logic                                      req;
   logic                                      accept;
   logic                                      tx_clear;
   logic                                      rx_clear;
   logic                                      busy;
   logic                                      tx_not_full;
   logic                                      tx_empty;
   logic                                      rx_nempty;
   logic                                      rx_full;
   logic [15:0]                               status_word;
   logic [31:0]                               rd_mux;
   logic [uart_stat_pkg::IRQ_W-1:0]           events;
   logic [uart_stat_pkg::IRQ_W-1:0]           rd_clear;

   // ------------------------------------------------------------------------
   // Queue level tracking.
   // ------------------------------------------------------------------------

   // Levels stay at zero for as long as the controller reset is held.
   assign tx_clear = st_nxt.tx_flush | ~ctrl_rst_n;
   assign rx_clear = st_nxt.rx_flush | ~ctrl_rst_n;

   occupancy_counter u_tx_count (
      .i_core_clk (i_core_clk),
      .i_nrst     (i_nrst),
      .i_evt      (i_tx_evt),
      .i_clear    (tx_clear),
      .o_level    (tx_level)
   );

   occupancy_counter u_rx_count (
      .i_core_clk (i_core_clk),
      .i_nrst     (i_nrst),
      .i_evt      (i_rx_evt),
      .i_clear    (rx_clear),
      .o_level    (rx_level)
   );

   // ------------------------------------------------------------------------
   // Controller reset generation.
   // ------------------------------------------------------------------------

   // One synchronised reset feeds both the bus side and the serial side of the core.
   reset_release_sync u_ctrl_rst (
      .i_core_clk (i_core_clk),
      .i_nrst     (i_nrst),
      .i_rst_req  (st_r.soft_rst_req),
      .o_rst_n    (ctrl_rst_n)
   );

   // ------------------------------------------------------------------------
   // Status flags.
   // ------------------------------------------------------------------------

   // Busy ignores a start bit not yet validated by the core, so it may read low briefly.
   assign busy        = st_r.act_flt | (tx_level != uart_stat_pkg::LEVEL_ZERO)
                        | (rx_level != uart_stat_pkg::LEVEL_ZERO);
   assign tx_not_full = (tx_level != uart_stat_pkg::FIFO_DEPTH);
   assign tx_empty    = (tx_level == uart_stat_pkg::LEVEL_ZERO);
   assign rx_nempty   = (rx_level != uart_stat_pkg::LEVEL_ZERO);
   assign rx_full     = (rx_level == uart_stat_pkg::FIFO_DEPTH);

   // Pack the flag word; upper bits read as zero.
   always_comb begin
      status_word                              = 16'h0000;
      status_word[uart_stat_pkg::ST_BUSY]      = busy;
      status_word[uart_stat_pkg::ST_TX_NFULL]  = tx_not_full;
      status_word[uart_stat_pkg::ST_TX_EMPTY]  = tx_empty;
      status_word[uart_stat_pkg::ST_RX_NEMPTY] = rx_nempty;
      status_word[uart_stat_pkg::ST_RX_FULL]   = rx_full;
   end

   // ------------------------------------------------------------------------
   // Read multiplexer.
   // ------------------------------------------------------------------------

   // Unmapped addresses and the write-only reset register read as zero.
   always_comb begin
      rd_mux = 32'h00000000;
      case (i_avs_address)
         uart_stat_pkg::ADDR_STATUS:     rd_mux = {16'h0000, status_word};
         uart_stat_pkg::ADDR_TX_LEVEL:   rd_mux = {27'h0000000, tx_level};
         uart_stat_pkg::ADDR_RX_LEVEL:   rd_mux = {27'h0000000, rx_level};
         uart_stat_pkg::ADDR_SOFT_RST:   rd_mux = 32'h00000000;
         uart_stat_pkg::ADDR_IRQ_STATUS: rd_mux = {29'h00000000, st_r.irq_status};
         uart_stat_pkg::ADDR_IRQ_MASK:   rd_mux = {29'h00000000, st_r.irq_mask};
         default:                        rd_mux = 32'h00000000;
      endcase
   end

   // ------------------------------------------------------------------------
   // Bus handshake and event detection.
   // ------------------------------------------------------------------------

   // A request is answered one cycle after it is seen; it takes effect when waitrequest is low.
   assign req    = i_avs_read | i_avs_write;
   assign accept = req & ~st_r.waitreq;

   // Rising edges of the queue flags are the interrupt events.
   always_comb begin
      events                              = '0;
      events[uart_stat_pkg::IRQ_TX_EMPTY] = tx_empty & ~st_r.prev_tx_empty;
      events[uart_stat_pkg::IRQ_RX_AVAIL] = rx_nempty & ~st_r.prev_rx_nempty;
      events[uart_stat_pkg::IRQ_RX_FULL]  = rx_full & ~st_r.prev_rx_full;
   end

   // Only bits actually returned to software are cleared, so a later event survives the read.
   assign rd_clear = (accept && i_avs_read && i_avs_address == uart_stat_pkg::ADDR_IRQ_STATUS)
                     ? st_r.cap_irq : '0;

   // ------------------------------------------------------------------------
   // Next-state logic.
   // ------------------------------------------------------------------------
   always_comb begin
      st_nxt              = st_r;
      st_nxt.waitreq      = 1'b1;
      st_nxt.tx_flush     = i_fcr_tx_flush;
      st_nxt.rx_flush     = i_fcr_rx_flush;
      st_nxt.soft_rst_req = 1'b0;

      // Three-stage capture of the serial activity level; a change counts when stages two and three agree.
      st_nxt.act_s1 = i_serial_active;
      st_nxt.act_s2 = st_r.act_s1;
      st_nxt.act_s3 = st_r.act_s2;
      if (st_r.act_s2 == st_r.act_s3) begin
         st_nxt.act_flt = st_r.act_s2;
      end

      st_nxt.prev_tx_empty  = tx_empty;
      st_nxt.prev_rx_nempty = rx_nempty;
      st_nxt.prev_rx_full   = rx_full;

      // First cycle of a request: capture read data and drop waitrequest.
      if (req && st_r.waitreq) begin
         st_nxt.waitreq = 1'b0;
         st_nxt.rdata   = i_avs_read ? rd_mux : 32'h00000000;
         st_nxt.cap_irq = st_r.irq_status;
      end

      // Completing edge: writes take effect; zeros written to the reset register do nothing.
      if (accept && i_avs_write && i_avs_byteenable[0]) begin
         case (i_avs_address)
            uart_stat_pkg::ADDR_SOFT_RST: begin
               if (i_avs_writedata[uart_stat_pkg::SR_TX_FLUSH]) begin
                  st_nxt.tx_flush = 1'b1;
               end
               if (i_avs_writedata[uart_stat_pkg::SR_RX_FLUSH]) begin
                  st_nxt.rx_flush = 1'b1;
               end
               if (i_avs_writedata[uart_stat_pkg::SR_CTRL_RST]) begin
                  st_nxt.soft_rst_req = 1'b1;
               end
            end
            uart_stat_pkg::ADDR_IRQ_MASK: begin
               st_nxt.irq_mask = i_avs_writedata[uart_stat_pkg::IRQ_W-1:0];
            end
            default: begin
               st_nxt.irq_mask = st_r.irq_mask;
            end
         endcase
      end

      // Set wins over the read clear.
      st_nxt.irq_status = (st_r.irq_status & ~rd_clear) | events;
      st_nxt.irq        = |(st_nxt.irq_status & st_nxt.irq_mask);
   end

   // ------------------------------------------------------------------------
   // State register.
   // ------------------------------------------------------------------------
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         st_r.waitreq        <= 1'b1;
         st_r.rdata          <= uart_stat_pkg::RDATA_RESET;
         st_r.cap_irq        <= '0;
         st_r.act_s1         <= 1'b0;
         st_r.act_s2         <= 1'b0;
         st_r.act_s3         <= 1'b0;
         st_r.act_flt        <= 1'b0;
         st_r.tx_flush       <= 1'b0;
         st_r.rx_flush       <= 1'b0;
         st_r.soft_rst_req   <= 1'b0;
         st_r.irq_status     <= '0;
         st_r.irq_mask       <= uart_stat_pkg::IRQ_MASK_RESET;
         st_r.irq            <= 1'b0;
         st_r.prev_tx_empty  <= 1'b1;
         st_r.prev_rx_nempty <= 1'b0;
         st_r.prev_rx_full   <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ------------------------------------------------------------------------
   // Outputs.
   // ------------------------------------------------------------------------
   assign o_avs_readdata    = st_r.rdata;
   assign o_avs_waitrequest = st_r.waitreq;
   assign o_tx_flush        = st_r.tx_flush;
   assign o_rx_flush        = st_r.rx_flush;
   assign o_ctrl_rst_n      = ctrl_rst_n;
   assign o_serial_rst_n    = ctrl_rst_n;
   assign o_irq             = st_r.irq;

   // ------------------------------------------------------------------------
   // Assertions.
   // ------------------------------------------------------------------------
   AST_TX_NOT_FULL: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      (i_avs_read && st_r.waitreq && i_avs_address == uart_stat_pkg::ADDR_STATUS)
      |=> o_avs_readdata[1] == ($past(tx_level) != uart_stat_pkg::FIFO_DEPTH))
      else $error("Transmit not-full flag wrong.");

   AST_BUSY_FLAG: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      (i_avs_read && st_r.waitreq && i_avs_address == uart_stat_pkg::ADDR_STATUS
       && (tx_level != uart_stat_pkg::LEVEL_ZERO)) |=> o_avs_readdata[0] && !o_avs_waitrequest)
      else $error("Busy flag low with data queued.");

   AST_BUSY_IDLE: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      (i_avs_read && st_r.waitreq && i_avs_address == uart_stat_pkg::ADDR_STATUS && !st_r.act_flt
       && tx_level == uart_stat_pkg::LEVEL_ZERO && rx_level == uart_stat_pkg::LEVEL_ZERO)
      |=> !o_avs_readdata[0]) else $error("Busy flag high while idle.");

   AST_ACTIVE_DELAY: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      $rose(st_r.act_flt) |-> ($past(i_serial_active, 3) && $past(i_serial_active, 4)))
      else $error("Serial activity taken without stable capture.");

   AST_TX_LEVEL: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      (i_avs_read && st_r.waitreq && i_avs_address == uart_stat_pkg::ADDR_TX_LEVEL)
      |=> o_avs_readdata == {27'h0000000, $past(tx_level)}) else $error("Transmit level wrong.");

   AST_RX_LEVEL: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      (i_avs_read && st_r.waitreq && i_avs_address == uart_stat_pkg::ADDR_RX_LEVEL)
      |=> o_avs_readdata == {27'h0000000, $past(rx_level)}) else $error("Receive level wrong.");

   AST_TX_FLUSH: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      (accept && i_avs_write && i_avs_byteenable[0] && i_avs_address == uart_stat_pkg::ADDR_SOFT_RST
       && i_avs_writedata[2]) |=> o_tx_flush && tx_level == uart_stat_pkg::LEVEL_ZERO)
      else $error("Transmit flush did not empty queue.");

   AST_RX_FLUSH: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      (accept && i_avs_write && i_avs_byteenable[0] && i_avs_address == uart_stat_pkg::ADDR_SOFT_RST
       && i_avs_writedata[1]) |=> o_rx_flush && rx_level == uart_stat_pkg::LEVEL_ZERO)
      else $error("Receive flush did not empty queue.");

   AST_FCR_FLUSH: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      (i_fcr_tx_flush || i_fcr_rx_flush) |=> ((o_tx_flush == $past(i_fcr_tx_flush)) || o_tx_flush)
      && ((o_rx_flush == $past(i_fcr_rx_flush)) || o_rx_flush) && (o_tx_flush || o_rx_flush))
      else $error("Control register flush not forwarded.");

   AST_CTRL_RESET: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      (accept && i_avs_write && i_avs_byteenable[0] && i_avs_address == uart_stat_pkg::ADDR_SOFT_RST
       && i_avs_writedata[0]) |=> !o_ctrl_rst_n [*3] ##1 o_ctrl_rst_n)
      else $error("Controller reset timing wrong.");

   AST_SERIAL_RESET: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      $fell(o_ctrl_rst_n) |-> !o_serial_rst_n ##1 !o_serial_rst_n ##1 !o_serial_rst_n)
      else $error("Serial side reset not held.");

   AST_RX_NEMPTY: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      (i_avs_read && st_r.waitreq && i_avs_address == uart_stat_pkg::ADDR_STATUS)
      |=> o_avs_readdata[3] == ($past(rx_level) != uart_stat_pkg::LEVEL_ZERO))
      else $error("Receive not-empty flag wrong.");

   AST_TX_EMPTY: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      (i_avs_read && st_r.waitreq && i_avs_address == uart_stat_pkg::ADDR_STATUS)
      |=> o_avs_readdata[2] == ($past(tx_level) == uart_stat_pkg::LEVEL_ZERO))
      else $error("Transmit empty flag wrong.");

   AST_SOFT_RST_READ: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      (i_avs_read && st_r.waitreq && i_avs_address == uart_stat_pkg::ADDR_SOFT_RST)
      |=> o_avs_readdata == 32'h00000000) else $error("Reset register read not zero.");

   AST_IRQ_LEVEL: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      o_irq == |(st_r.irq_status & st_r.irq_mask)) else $error("Interrupt output mismatch.");

endmodule : uart_status_ctrl

// ===== bench/serial_peer.sv
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Remote serial device: shows line activity for one frame on request.
// ------------------------------------------------------------------
module serial_peer (
   input  wire logic i_core_clk,
   input  wire logic i_send,
   output logic      o_active = 1'h0
);
   int n = 0;
   // The peer is quiet outside a frame, so busy must come from real traffic.
   always @(posedge i_core_clk) begin
      n <= i_send ? 40 : (n > 0 ? n - 1 : 0);
      o_active <= i_send || n > 1;
   end
endmodule : serial_peer

// ===== bench/uart_fifo_status_and_soft_reset_test.sv
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_fail++; $display("[ERR] t=%0t got %h exp %h", $time, a, e); end end
module uart_fifo_status_and_soft_reset_test;
   logic                     clk = 1'h0, nrst = 1'h0, rd = 1'h0, wr = 1'h0, txf = 1'h0, rxf = 1'h0, send = 1'h0;
   logic                     act, wreq, irq, tfl, rfl, crn, srn;
   logic [31:0]              adr = 32'h0, wdat = 32'h0, rdat, q;
   uart_stat_pkg::fifo_evt_t tev = 2'h0, rev = 2'h0;
   int                       n_fail = 0, cmp_count = 0, st = 34322, txl = 0, rxl = 0;
   uart_status_ctrl u_uart_status_ctrl (.i_core_clk(clk), .i_nrst(nrst), .i_avs_address(adr), .i_avs_read(rd),
      .i_avs_write(wr), .i_avs_writedata(wdat), .i_avs_byteenable(4'hF), .o_avs_readdata(rdat),
      .o_avs_waitrequest(wreq), .i_tx_evt(tev), .i_rx_evt(rev), .i_fcr_tx_flush(txf), .i_fcr_rx_flush(rxf),
      .i_serial_active(act), .o_tx_flush(tfl), .o_rx_flush(rfl), .o_ctrl_rst_n(crn), .o_serial_rst_n(srn),
      .o_irq(irq));
   serial_peer u_serial_peer (.i_core_clk(clk), .i_send(send), .o_active(act));
   // ------------------------------------------------------------------
   // Model and bus helpers.
   // ------------------------------------------------------------------
   function automatic int rnd();
      st ^= st << 13;
      st ^= st >> 17;
      st ^= st << 5;
      return st & 32'h7FFFFFFF;
   endfunction : rnd
   function automatic logic [31:0] exp_st(input logic busy);
      return {27'h0, rxl == 16, rxl != 0, txl == 0, txl != 16, busy || txl != 0 || rxl != 0};
   endfunction : exp_st
   // Waitrequest and read data are taken at the rising edge, before that edge's own update lands.
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      rd <= !w; wr <= w; adr <= a; wdat <= d;
      do @(posedge clk); while (wreq !== 1'h0);
      q = rdat;
      rd <= 1'h0; wr <= 1'h0;
   endtask : bus
   task automatic ev(input logic rx, input int n);
      repeat (n) begin
         @(posedge clk);
         if (rx) rev <= 2'h2; else tev <= 2'h2;
         if (rx && rxl < 16) rxl++; else if (!rx && txl < 16) txl++;
      end
      @(posedge clk);
      tev <= 2'h0; rev <= 2'h0;
   endtask : ev
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : give_verdict
   // Free-running clock and a watchdog far beyond the few hundred cycles needed.
   initial forever #12.5 clk = ~clk;
   initial begin
      #(25 * 3000);
      n_fail++;
      give_verdict();
   end
   // ------------------------------------------------------------------
   // Test sequence.
   // ------------------------------------------------------------------
   initial begin
      repeat (10) @(posedge clk);
      nrst <= 1'h1;
      bus(1'h0, uart_stat_pkg::ADDR_STATUS, 32'h0); `CHK(q, exp_st(1'h0))
      for (int i = 0; i < 4; i++) begin
         bus(1'h0, uart_stat_pkg::ADDR_TX_LEVEL + 32'(4 * i), 32'h0); `CHK(q, 32'h0)
      end
      $display("reset values done");
      ev(1'h0, 17);
      bus(1'h0, uart_stat_pkg::ADDR_STATUS, 32'h0); `CHK(q, exp_st(1'h0))
      bus(1'h1, uart_stat_pkg::ADDR_IRQ_MASK, 32'h2);
      bus(1'h0, uart_stat_pkg::ADDR_IRQ_STATUS, 32'h0);
      ev(1'h1, 1 + rnd() % 15);
      repeat (2) @(posedge clk);
      `CHK(irq, 1'h1)
      bus(1'h0, uart_stat_pkg::ADDR_RX_LEVEL, 32'h0); `CHK(q, 32'(rxl))
      bus(1'h0, uart_stat_pkg::ADDR_STATUS, 32'h0); `CHK(q, exp_st(1'h0))
      bus(1'h0, uart_stat_pkg::ADDR_IRQ_STATUS, 32'h0); `CHK(q, 32'h2)
      bus(1'h1, uart_stat_pkg::ADDR_SOFT_RST, 32'h0); `CHK(irq, 1'h0)
      bus(1'h0, uart_stat_pkg::ADDR_TX_LEVEL, 32'h0); `CHK(q, 32'(txl))
      $display("levels done");
      bus(1'h1, uart_stat_pkg::ADDR_SOFT_RST, 32'h4);
      @(negedge clk) `CHK(tfl, 1'h1)
      @(negedge clk) `CHK(tfl, 1'h0)
      txl = 0;
      bus(1'h0, uart_stat_pkg::ADDR_TX_LEVEL, 32'h0); `CHK(q, 32'h0)
      @(posedge clk) rxf <= 1'h1;
      @(posedge clk) rxf <= 1'h0;
      @(negedge clk) `CHK(rfl, 1'h1)
      rxl = 0;
      bus(1'h0, uart_stat_pkg::ADDR_RX_LEVEL, 32'h0); `CHK(q, 32'h0)
      ev(1'h1, 2);
      bus(1'h1, uart_stat_pkg::ADDR_SOFT_RST, 32'h2);
      @(negedge clk) `CHK(rfl, 1'h1)
      rxl = 0;
      bus(1'h0, uart_stat_pkg::ADDR_RX_LEVEL, 32'h0); `CHK(q, 32'h0)
      @(posedge clk) send <= 1'h1;
      @(posedge clk) send <= 1'h0;
      repeat (8) @(posedge clk);
      bus(1'h0, uart_stat_pkg::ADDR_STATUS, 32'h0); `CHK(q, exp_st(1'h1))
      repeat (50) @(posedge clk);
      bus(1'h0, uart_stat_pkg::ADDR_STATUS, 32'h0); `CHK(q, exp_st(1'h0))
      $display("flush and busy done");
      ev(1'h0, 3);
      bus(1'h1, uart_stat_pkg::ADDR_SOFT_RST, 32'h1);
      @(negedge clk);
      `CHK({crn, srn}, 2'h0)
      repeat (5) @(posedge clk);
      txl = 0;
      bus(1'h0, uart_stat_pkg::ADDR_TX_LEVEL, 32'h0); `CHK(q, 32'h0)
      `CHK({crn, srn}, 2'h3)
      ev(1'h1, 17);
      bus(1'h0, uart_stat_pkg::ADDR_STATUS, 32'h0); `CHK(q, exp_st(1'h0))
      $display("soft reset done");
      give_verdict();
   end
endmodule : uart_fifo_status_and_soft_reset_test
